/* File: rtl/psr_map.svh */
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH
// register byte offsets
`define PSR_OFF_EXPR     12'h000
`define PSR_OFF_SUS      12'h004
`define PSR_OFF_PANEL    12'h008
`define PSR_OFF_DISP     12'h00C
`define PSR_OFF_STATUS   12'h010
`define PSR_OFF_FADER    12'h014
// reset values and display limits
`define PSR_DEST_RST     3'h0
`define PSR_SUS_RST      4'h0
`define PSR_PANEL_RST    5'h1D
`define PSR_BRIGHT_RST   7'h64
`define PSR_BRIGHT_MAX   7'h64
`define PSR_CONTR_RST    4'hA
`define PSR_CONTR_MAX    4'hE
// panel field positions
`define PSR_PNL_LOCAL    0
`define PSR_PNL_PICKUP   1
`define PSR_PNL_INFO     2
`define PSR_PNL_CYCLE    3
`define PSR_PNL_PAGEMEM  4
// debounce time
`define PSR_DEB_US       1000
`define PSR_CLK_MHZ      50
`define PSR_DEB_CYC      (`PSR_DEB_US * `PSR_CLK_MHZ)
`endif

/* File: rtl/psr_pkg.sv */
package psr_pkg;
  typedef enum logic [2:0] {
    PSR_DST_FOOT, PSR_DST_MODW, PSR_DST_BREATH, PSR_DST_VOL, PSR_DST_EXPR
  } psr_dest_t;
  typedef enum logic [3:0] {
    PSR_SUS_NO, PSR_SUS_NC, PSR_TAP_NO, PSR_TAP_NC, PSR_ARP_HI, PSR_ARP_LO,
    PSR_SEQ_RISE, PSR_SEQ_FALL, PSR_ARPSEQ_HI, PSR_ARPSEQ_LO
  } psr_sus_t;
  typedef struct packed {
    logic foot;
    logic modw;
    logic breath;
    logic vol;
    logic expr;
  } psr_route_t;
  typedef struct packed {
    logic sustain_hold;
    logic tap;
    logic arp_step;
    logic arp_gate;
    logic seq_step;
  } psr_events_t;
endpackage

/* File: rtl/psr_router.sv */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "psr_map.svh"
module psr_router
  import psr_pkg::*;
#(
  parameter int DEB_CYC = `PSR_DEB_CYC
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [11:0] EXPR_SAMPLE_I,
  input  wire logic        SUS_PIN_I,
  input  wire logic        PANEL_EDIT_I,
  input  wire logic [7:0]  FADER_POS_I,
  input  wire logic [7:0]  FADER_STORED_I,
  input  wire logic        FADER_MOVED_I,
  output logic      [11:0] EXPR_VALUE_O,
  output psr_route_t       EXPR_ROUTE_O,
  output psr_events_t      SUS_EVENTS_O,
  output logic             PANEL_EDIT_O,
  output logic             FADER_WRITE_O,
  output logic      [7:0]  FADER_VALUE_O,
  output logic             CYCLE_HOME_O,
  output logic             PAGE_MEMORY_O,
  output logic             INFO_DIALOGS_O,
  output logic      [6:0]  BRIGHT_O,
  output logic      [3:0]  CONTRAST_O
);

  // ==========================================================
  // registers
  psr_dest_t   dest;
  psr_sus_t    sus_mode;
  logic [4:0]  panel;
  logic [6:0]  bright;
  logic [3:0]  contr;
  logic        wr_en;
  logic        rd_en;
  logic        bad_addr;
  logic        level;
  logic        armed;
  logic        side_lo;

  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;
  assign PREADY_O = 1'b1;

  always_comb begin
    bad_addr = 1'b0;
    if (PADDR_I[1:0] != 2'h0) begin
      bad_addr = 1'b1;
    end else if (PADDR_I > `PSR_OFF_FADER) begin
      bad_addr = 1'b1;
    end
  end
  assign PSLVERR_O = PSEL_I & PENABLE_I & bad_addr;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dest <= PSR_DST_FOOT;
    end else if (wr_en && PADDR_I == `PSR_OFF_EXPR && PWDATA_I[2:0] <= 3'h4) begin
      dest <= psr_dest_t'(PWDATA_I[2:0]);
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sus_mode <= PSR_SUS_NO;
    end else if (wr_en && PADDR_I == `PSR_OFF_SUS && PWDATA_I[3:0] <= 4'h9) begin
      sus_mode <= psr_sus_t'(PWDATA_I[3:0]);
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      panel <= `PSR_PANEL_RST;
    end else if (wr_en && PADDR_I == `PSR_OFF_PANEL) begin
      panel <= PWDATA_I[4:0];
    end
  end

  // out-of-range writes are clamped so the display never sees junk
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bright <= `PSR_BRIGHT_RST;
      contr  <= `PSR_CONTR_RST;
    end else if (wr_en && PADDR_I == `PSR_OFF_DISP) begin
      bright <= (PWDATA_I[6:0] > `PSR_BRIGHT_MAX) ? `PSR_BRIGHT_MAX : PWDATA_I[6:0];
      contr  <= (PWDATA_I[11:8] > `PSR_CONTR_MAX) ? `PSR_CONTR_MAX : PWDATA_I[11:8];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      if (PADDR_I == `PSR_OFF_EXPR) begin
        PRDATA_O <= {29'h0, dest};
      end else if (PADDR_I == `PSR_OFF_SUS) begin
        PRDATA_O <= {28'h0, sus_mode};
      end else if (PADDR_I == `PSR_OFF_PANEL) begin
        PRDATA_O <= {27'h0, panel};
      end else if (PADDR_I == `PSR_OFF_DISP) begin
        PRDATA_O <= {20'h0, contr, 1'b0, bright};
      end else if (PADDR_I == `PSR_OFF_STATUS) begin
        PRDATA_O <= {4'h0, EXPR_VALUE_O, 13'h0, side_lo, armed, level};
      end else if (PADDR_I == `PSR_OFF_FADER) begin
        PRDATA_O <= {24'h0, FADER_VALUE_O};
      end else begin
        PRDATA_O <= 32'h0;
      end
    end
  end

  // ==========================================================
  // expression input
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      EXPR_VALUE_O <= 12'h000;
    end else begin
      EXPR_VALUE_O <= EXPR_SAMPLE_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      EXPR_ROUTE_O <= '0;
    end else begin
      EXPR_ROUTE_O.foot   <= (dest == PSR_DST_FOOT);
      EXPR_ROUTE_O.modw   <= (dest == PSR_DST_MODW);
      EXPR_ROUTE_O.breath <= (dest == PSR_DST_BREATH);
      EXPR_ROUTE_O.vol    <= (dest == PSR_DST_VOL);
      EXPR_ROUTE_O.expr   <= (dest == PSR_DST_EXPR);
    end
  end

  // ==========================================================
  // sustain / gate input: sync, agree, debounce
  logic [2:0]  sync;
  logic [22:0] deb_cnt;
  logic        level_d;
  logic        rise;
  logic        fall;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], SUS_PIN_I};
    end
  end

  // level moves only after the synced value stays changed a full debounce time
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      deb_cnt <= 23'h0;
      level   <= 1'b0;
    end else if (sync[2] != sync[1] || sync[2] == level) begin
      deb_cnt <= 23'h0;
    end else if (deb_cnt == 23'(DEB_CYC - 1)) begin
      deb_cnt <= 23'h0;
      level   <= sync[2];
    end else begin
      deb_cnt <= deb_cnt + 23'h1;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      level_d <= 1'b0;
    end else begin
      level_d <= level;
    end
  end
  assign rise = level & ~level_d;
  assign fall = ~level & level_d;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SUS_EVENTS_O <= '0;
    end else begin
      SUS_EVENTS_O <= '0;
      case (sus_mode)
        PSR_SUS_NO:    SUS_EVENTS_O.sustain_hold <= level;
        PSR_SUS_NC:    SUS_EVENTS_O.sustain_hold <= ~level;
        PSR_TAP_NO:    SUS_EVENTS_O.tap <= rise;
        PSR_TAP_NC:    SUS_EVENTS_O.tap <= fall;
        PSR_ARP_HI: begin
          SUS_EVENTS_O.arp_step <= rise;
          SUS_EVENTS_O.arp_gate <= level;
        end
        PSR_ARP_LO: begin
          SUS_EVENTS_O.arp_step <= fall;
          SUS_EVENTS_O.arp_gate <= ~level;
        end
        PSR_SEQ_RISE:  SUS_EVENTS_O.seq_step <= rise;
        PSR_SEQ_FALL:  SUS_EVENTS_O.seq_step <= fall;
        PSR_ARPSEQ_HI: begin
          SUS_EVENTS_O.arp_step <= rise;
          SUS_EVENTS_O.arp_gate <= level;
          SUS_EVENTS_O.seq_step <= rise;
        end
        PSR_ARPSEQ_LO: begin
          SUS_EVENTS_O.arp_step <= fall;
          SUS_EVENTS_O.arp_gate <= ~level;
          SUS_EVENTS_O.seq_step <= fall;
        end
        default:       SUS_EVENTS_O <= '0;
      endcase
    end
  end

  // ==========================================================
  // panel settings and fader behaviour
  logic local_on;
  logic pickup;
  logic pos_ge;

  assign local_on = panel[`PSR_PNL_LOCAL];
  assign pickup   = panel[`PSR_PNL_PICKUP];
  assign pos_ge   = FADER_POS_I >= FADER_STORED_I;

  // pickup arms on first move, remembering which side of the stored value it started
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      armed   <= 1'b0;
      side_lo <= 1'b0;
    end else if (!pickup) begin
      armed <= 1'b0;
    end else if (FADER_MOVED_I && local_on && !armed) begin
      armed   <= 1'b1;
      side_lo <= ~pos_ge;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FADER_WRITE_O <= 1'b0;
      FADER_VALUE_O <= 8'h00;
    end else begin
      FADER_WRITE_O <= 1'b0;
      if (FADER_MOVED_I && local_on) begin
        if (!pickup) begin
          FADER_WRITE_O <= 1'b1;
          FADER_VALUE_O <= FADER_POS_I;
        end else if (armed && (side_lo ? pos_ge : FADER_POS_I <= FADER_STORED_I)) begin
          FADER_WRITE_O <= 1'b1;
          FADER_VALUE_O <= FADER_POS_I;
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PANEL_EDIT_O   <= 1'b0;
      CYCLE_HOME_O   <= 1'b1;
      PAGE_MEMORY_O  <= 1'b1;
      INFO_DIALOGS_O <= 1'b1;
      BRIGHT_O       <= `PSR_BRIGHT_RST;
      CONTRAST_O     <= `PSR_CONTR_RST;
    end else begin
      PANEL_EDIT_O   <= PANEL_EDIT_I & local_on;
      CYCLE_HOME_O   <= panel[`PSR_PNL_CYCLE];
      PAGE_MEMORY_O  <= panel[`PSR_PNL_PAGEMEM];
      INFO_DIALOGS_O <= panel[`PSR_PNL_INFO];
      BRIGHT_O       <= bright;
      CONTRAST_O     <= contr;
    end
  end

  // ==========================================================
  // assertions
  // route flops load one edge after reset lets go, so that first edge is skipped
  a_route_onehot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $past(RST_N_I) |-> $onehot(EXPR_ROUTE_O)) else $error("route not one-hot");
  a_expr_follow: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 EXPR_VALUE_O == $past(EXPR_SAMPLE_I)) else $error("expr value lag");
  a_hold_no: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_SUS_NO && $stable(sus_mode) |=> SUS_EVENTS_O.sustain_hold == $past(level))
    else $error("no sustain wrong");
  a_hold_nc: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_SUS_NC |=> SUS_EVENTS_O.sustain_hold == !$past(level))
    else $error("nc sustain wrong");
  a_tap_pulse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    SUS_EVENTS_O.tap |=> !SUS_EVENTS_O.tap) else $error("tap longer than a cycle");
  a_tap_close: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_TAP_NO && rise |=> SUS_EVENTS_O.tap) else $error("tap missed");
  a_seq_fall: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_SEQ_FALL && fall |=> SUS_EVENTS_O.seq_step) else $error("seq step missed");
  a_local_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !local_on |=> !FADER_WRITE_O && !PANEL_EDIT_O) else $error("edit with local off");
  a_jump_fader: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    FADER_MOVED_I && local_on && !pickup |=> FADER_WRITE_O && FADER_VALUE_O == $past(FADER_POS_I))
    else $error("jump not applied");
  a_disp_range: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    BRIGHT_O <= `PSR_BRIGHT_MAX && CONTRAST_O <= `PSR_CONTR_MAX) else $error("display range");
  a_route_expr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 EXPR_ROUTE_O.expr == ($past(dest) == PSR_DST_EXPR)) else $error("route lost dest");
  a_mode_reset: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(RST_N_I) |-> sus_mode == PSR_SUS_NO && panel == `PSR_PANEL_RST)
    else $error("reset mode wrong");

  // event modes and debounce: tap, arp and seq event outputs against the level and edges they come from, and level against sync and count
  a_tap_open: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_TAP_NC && fall |=> SUS_EVENTS_O.tap) else $error("open tap missed");
  a_tap_nohold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_TAP_NO || sus_mode == PSR_TAP_NC |=> !SUS_EVENTS_O.sustain_hold)
    else $error("tap mode holds sustain");
  a_arp_high: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_ARP_HI |=> SUS_EVENTS_O.arp_step == $past(rise)
      && SUS_EVENTS_O.arp_gate == $past(level)) else $error("arp high gate wrong");
  a_arp_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_ARP_LO |=> SUS_EVENTS_O.arp_step == $past(fall)
      && SUS_EVENTS_O.arp_gate == !$past(level)) else $error("arp low gate wrong");
  a_seq_rise: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_SEQ_RISE && rise |=> SUS_EVENTS_O.seq_step)
    else $error("rise step missed");
  a_combo_high: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_ARPSEQ_HI |=> SUS_EVENTS_O.arp_step == $past(rise)
      && SUS_EVENTS_O.seq_step == $past(rise) && SUS_EVENTS_O.arp_gate == $past(level))
    else $error("combined high wrong");
  a_combo_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sus_mode == PSR_ARPSEQ_LO |=> SUS_EVENTS_O.arp_step == $past(fall)
      && SUS_EVENTS_O.seq_step == $past(fall) && SUS_EVENTS_O.arp_gate == !$past(level))
    else $error("combined low wrong");
  a_step_pulse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    SUS_EVENTS_O.arp_step || SUS_EVENTS_O.seq_step |=> !SUS_EVENTS_O.arp_step
      && !SUS_EVENTS_O.seq_step) else $error("step longer than a cycle");
  a_level_agree: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $changed(level) |-> $past(sync[2]) == level && $past(sync[1]) == level)
    else $error("level moved without agreement");
  a_deb_span: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $changed(level) |-> $past(deb_cnt) == 23'(DEB_CYC - 1)) else $error("debounce span short");
  // an unarmed pickup fader must never write, whatever its position
  a_pickup_wait: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    pickup && !armed |=> !FADER_WRITE_O) else $error("pickup wrote before crossing");
  a_cycle_home: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 CYCLE_HOME_O == $past(panel[`PSR_PNL_CYCLE])) else $error("cycle home wrong");
  a_page_memory: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 PAGE_MEMORY_O == $past(panel[`PSR_PNL_PAGEMEM])) else $error("page memory wrong");
  a_disp_follow: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ##1 BRIGHT_O == $past(bright) && CONTRAST_O == $past(contr)) else $error("display lag");

endmodule
`default_nettype wire

/* File: verification/psr_router_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module psr_router_tb_top
  import psr_pkg::*;
;
  logic        clk, rst_n, psel, pen, pwr, pready, rerr, pslverr;
  logic [11:0] paddr, volt, sample, eval;
  logic [31:0] pwdata, prdata, rdata;
  logic        press, pin, edit_i, edit_o, moved, fwr, home, pmem, info;
  logic [7:0]  pos, stored, fval;
  logic [6:0]  bright;
  logic [3:0]  contr;
  psr_route_t  route;
  psr_events_t ev;
  int          mismatches = 0;
  int          total_checks = 0;

  psr_src_model src (.clk_i(clk), .press_i(press), .volt_i(volt), .pin_o(pin),
    .sample_o(sample));
  // short debounce keeps the run brief
  psr_router #(.DEB_CYC(4)) uut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .EXPR_SAMPLE_I(sample), .SUS_PIN_I(pin), .PANEL_EDIT_I(edit_i),
    .FADER_POS_I(pos), .FADER_STORED_I(stored), .FADER_MOVED_I(moved),
    .EXPR_VALUE_O(eval), .EXPR_ROUTE_O(route), .SUS_EVENTS_O(ev),
    .PANEL_EDIT_O(edit_o), .FADER_WRITE_O(fwr), .FADER_VALUE_O(fval),
    .CYCLE_HOME_O(home), .PAGE_MEMORY_O(pmem), .INFO_DIALOGS_O(info),
    .BRIGHT_O(bright), .CONTRAST_O(contr));

  // ========
  // bus and checks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ========
  // scenarios
  task automatic t_reset();
    apb(1'b0, 12'h008, 32'h0);
    chk("panel", rdata, 32'h0000_001D);
    apb(1'b0, 12'h00C, 32'h0);
    chk("display", rdata, 32'h0000_0A64);
    apb(1'b0, 12'h004, 32'h0);
    chk("sus mode", rdata, 32'h0);
    chk("route", route, 5'h10);
    chk("outs", {home, pmem, bright, contr}, {2'b11, 7'h64, 4'hA});
    $display("test reset done");
  endtask

  task automatic t_route();
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, i);
      volt <= 12'(i * 12'h3FF);
      repeat (3) @(posedge clk);
      chk("route", route, 5'h10 >> i);
      chk("value", eval, 12'(i * 12'h3FF));
    end
    apb(1'b1, 12'h000, 32'h5);
    repeat (2) @(posedge clk);
    chk("route kept", route, 5'h01);
    $display("test route done");
  endtask

  task automatic t_sustain();
    logic [31:0] taps, seqs, arps;
    psr_events_t hi;
    for (int m = 0; m < 10; m++) begin
      apb(1'b1, 12'h004, m);
      taps = 0;
      seqs = 0;
      arps = 0;
      for (int c = 0; c < 40; c++) begin
        press <= (c < 20);
        @(posedge clk);
        taps += ev.tap;
        seqs += ev.seq_step;
        arps += ev.arp_step;
        if (c == 19) hi = ev;
      end
      chk("hold", {hi.sustain_hold, ev.sustain_hold}, m == 0 ? 2'b10 : m == 1 ? 2'b01 : 2'b00);
      chk("gate", {hi.arp_gate, ev.arp_gate},
        (m == 4 || m == 8) ? 2'b10 : (m == 5 || m == 9) ? 2'b01 : 2'b00);
      chk("taps", taps, m == 2 || m == 3);
      chk("seq steps", seqs, m >= 6);
      chk("arp steps", arps, m inside {4, 5, 8, 9});
    end
    $display("test sustain done");
  endtask

  task automatic mv(input logic [7:0] p, input logic [31:0] n, input logic [7:0] v);
    logic [31:0] w;
    w = 0;
    pos <= p;
    moved <= 1'b1;
    @(posedge clk);
    moved <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      w += fwr;
    end
    chk("fader writes", w, n);
    if (n != 0) chk("fader value", fval, v);
  endtask

  task automatic t_panel();
    apb(1'b1, 12'h008, 32'h1C);
    edit_i <= 1'b1;
    repeat (2) @(posedge clk);
    chk("edit blocked", edit_o, 1'b0);
    mv(8'h33, 0, 8'h0);
    apb(1'b1, 12'h008, 32'h05);
    repeat (2) @(posedge clk);
    chk("edit", edit_o, 1'b1);
    chk("menu", {home, pmem, info}, 3'b001);
    mv(8'h33, 1, 8'h33);
    apb(1'b1, 12'h008, 32'h1F);
    stored <= 8'h80;
    mv(8'h40, 0, 8'h0);
    mv(8'h60, 0, 8'h0);
    mv(8'h90, 1, 8'h90);
    apb(1'b0, 12'h010, 32'h0);
    chk("status", rdata, 32'h0FFC_0006);
    apb(1'b0, 12'h014, 32'h0);
    chk("fader reg", rdata, 32'h0000_0090);
    $display("test panel done");
  endtask

  task automatic t_display();
    apb(1'b1, 12'h00C, 32'h0000_0F7F);
    apb(1'b0, 12'h00C, 32'h0);
    chk("clamped", rdata, 32'h0000_0E64);
    chk("outs", {bright, contr}, {7'h64, 4'hE});
    apb(1'b1, 12'h00C, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0);
    chk("lowest", {rdata[11:0], bright, contr}, {12'h0, 7'h0, 4'h0});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", {rerr, rdata}, {1'b1, 32'h0});
    $display("test display done");
  endtask

  // ========
  // run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  initial begin
    {rst_n, psel, pen, pwr, press, edit_i, moved} = '0;
    {paddr, volt, pwdata, pos, stored} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_route();
    t_sustain();
    t_panel();
    t_display();
    summarize();
  end
endmodule
`default_nettype wire

/* File: verification/psr_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// pedal and switch source
module psr_src_model (
  input  wire logic        clk_i,
  input  wire logic        press_i,
  input  wire logic [11:0] volt_i,
  output logic             pin_o,
  output logic      [11:0] sample_o
);
  logic [1:0] bounce = 2'h0;
  logic       last   = 1'b0;
  // real contacts chatter after each change, shorter than the debounce span
  always_ff @(posedge clk_i) begin
    last <= press_i;
    if (press_i != last) begin
      bounce <= 2'h3;
    end else if (bounce != 2'h0) begin
      bounce <= bounce - 2'h1;
    end
  end
  assign pin_o    = press_i ^ bounce[0];
  assign sample_o = volt_i;
endmodule
`default_nettype wire
